/* File: logic/rbm_defines.svh */
/*
 * Constants for the retentive bit memory: width, reset values, strap defaults.
 * Assumes it is included by its bare name from the logic/ folder.
 */
`ifndef RBM_DEFINES_SVH
`define RBM_DEFINES_SVH

// ****************************************************************
// Widths, reset values and strap defaults
// ****************************************************************
`define RBM_NUM_BITS     8
`define RBM_DATA_RST     8'h00
`define RBM_PREV_RST     1'b1
`define RBM_LEGACY_ERASE 1'b1

`endif

/* File: logic/rbm_pkg.sv */
/*
 * Types shared by the retentive bit memory files.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package rbm_pkg;

    // ****************************************************************
    // Controller phase as seen by the block
    // ****************************************************************
    typedef enum logic [1:0]
    {
        ST_LOAD,
        ST_STOP,
        ST_RUN
    } rbm_state_t;

endpackage : rbm_pkg

`default_nettype wire

/* File: logic/rbm_edge.sv */
/*
 * Rising edge detector sampled once per logic execution cycle.
 * Assumes level_i comes from logic on the same clock; rearm_i forces the
 * previous sample high so a level already high gives no edge.
 */
`include "rbm_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module rbm_edge
#(
    parameter int W = 2
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         tick_i,
    input  wire logic         rearm_i,
    input  wire logic [W-1:0] level_i,
    output logic      [W-1:0] rise_o
);

    logic [W-1:0] prev_reg;
    logic [W-1:0] prev_next;

    // ****************************************************************
    // Previous sample and edge
    // ****************************************************************

    // Rearm wins so power-up and restart never see a phantom edge
    always_comb
    begin
        prev_next = prev_reg;
        if (rearm_i)
            prev_next = {W{`RBM_PREV_RST}};
        else if (tick_i)
            prev_next = level_i;
    end

    // Registered copy of the last tick's sample
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            prev_reg <= {W{`RBM_PREV_RST}};
        else if (ce_i)
            prev_reg <= prev_next;
    end

    // Edge is only meaningful on a tick, the caller gates it
    assign rise_o = level_i & ~prev_reg;

endmodule : rbm_edge

`default_nettype wire

/* File: logic/rbm_top.sv */
/*
 * Retentive bit memory: latches input bits on a store edge, mirrors them to
 * a non-volatile store, reloads them after power-up.
 * Assumes the non-volatile store keeps NV_RDATA_I across power loss and
 * raises NV_RVALID_I once after reset; RST_I is the power-on reset.
 */
`include "rbm_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module rbm_top
#(
    parameter int   NUM_BITS     = `RBM_NUM_BITS,
    parameter logic LEGACY_ERASE = `RBM_LEGACY_ERASE
)
(
    input  wire logic                CLOCK_I,
    input  wire logic                RST_I,
    input  wire logic                CE_I,
    input  wire logic                LOGIC_TICK_I,
    input  wire logic                RUN_I,
    input  wire logic                STORE_I,
    input  wire logic                CLEAR_I,
    input  wire logic [NUM_BITS-1:0] DATA_I,
    input  wire logic [NUM_BITS-1:0] NV_RDATA_I,
    input  wire logic                NV_RVALID_I,
    input  wire logic                CARD_PRESENT_I,
    input  wire logic                PROJECT_LOAD_I,
    output logic      [NUM_BITS-1:0] DATA_O,
    output logic                     STATUS_O,
    output logic                     NV_WE_O,
    output logic      [NUM_BITS-1:0] NV_WDATA_O
);

    rbm_pkg::rbm_state_t     state_reg;
    rbm_pkg::rbm_state_t     state_next;
    logic [NUM_BITS-1:0]     data_reg;
    logic [NUM_BITS-1:0]     data_next;
    logic [NUM_BITS-1:0]     wdata_reg;
    logic [NUM_BITS-1:0]     wdata_next;
    logic                    we_reg;
    logic                    we_next;
    logic                    status_reg;
    logic                    status_next;
    logic                    armed_reg;
    logic                    armed_next;
    logic                    card_s1_reg;
    logic                    card_s2_reg;
    logic                    card_prev_reg;
    logic                    rearm;
    logic [1:0]              rise;
    logic                    store_rise;
    logic                    clear_rise;
    logic                    card_removed;
    logic                    legacy_evt;
    logic                    erase_req;

    // ****************************************************************
    // Card pin synchroniser
    // ****************************************************************

    // Pin is asynchronous; only the second stage and its copy are read
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            card_s1_reg   <= 1'b1;
            card_s2_reg   <= 1'b1;
            card_prev_reg <= 1'b1;
        end
        else if (CE_I)
        begin
            card_s1_reg   <= CARD_PRESENT_I;
            card_s2_reg   <= card_s1_reg;
            card_prev_reg <= card_s2_reg;
        end
    end

    // Removal while powered, or a new project, wipes the memory
    assign card_removed = card_prev_reg & ~card_s2_reg;
    assign legacy_evt   = LEGACY_ERASE & (card_removed | PROJECT_LOAD_I);

    // ****************************************************************
    // Strobe edges
    // ****************************************************************

    // Rearm during load and on stop-to-run so a held strobe is no edge
    assign rearm = (state_reg == rbm_pkg::ST_LOAD) |
                   ((state_reg == rbm_pkg::ST_STOP) & RUN_I);

    rbm_edge #(
        .W       (2)
    ) u_edge (
        .clk_i   (CLOCK_I),
        .rst_i   (RST_I),
        .ce_i    (CE_I),
        .tick_i  (LOGIC_TICK_I),
        .rearm_i (rearm),
        .level_i ({CLEAR_I, STORE_I}),
        .rise_o  (rise)
    );

    // Edges count only in the running phase on a logic tick
    assign store_rise = rise[0] & LOGIC_TICK_I & (state_reg == rbm_pkg::ST_RUN);
    assign clear_rise = rise[1] & LOGIC_TICK_I & (state_reg == rbm_pkg::ST_RUN);

    // Clear level acts only with store high and an armed clear
    assign erase_req = LOGIC_TICK_I & (state_reg == rbm_pkg::ST_RUN) &
                       STORE_I & CLEAR_I & (armed_reg | clear_rise);

    // ****************************************************************
    // Memory and phase control
    // ****************************************************************

    // Next values; legacy erase beats clear, clear beats store
    always_comb
    begin
        state_next = state_reg;
        data_next  = data_reg;
        wdata_next = wdata_reg;
        we_next    = 1'b0;
        armed_next = armed_reg;
        case (state_reg)
            rbm_pkg::ST_LOAD:
            begin
                armed_next = 1'b0;
                if (NV_RVALID_I)
                begin
                    data_next  = NV_RDATA_I;
                    state_next = RUN_I ? rbm_pkg::ST_RUN : rbm_pkg::ST_STOP;
                end
            end
            rbm_pkg::ST_STOP:
            begin
                armed_next = 1'b0;
                if (RUN_I)
                    state_next = rbm_pkg::ST_RUN;
            end
            rbm_pkg::ST_RUN:
            begin
                if (!RUN_I)
                    state_next = rbm_pkg::ST_STOP;
                if (LOGIC_TICK_I)
                begin
                    if (!CLEAR_I)
                        armed_next = 1'b0;
                    else if (clear_rise)
                        armed_next = 1'b1;
                end
                if (erase_req)
                begin
                    data_next  = {NUM_BITS{1'b0}};
                    wdata_next = {NUM_BITS{1'b0}};
                    we_next    = 1'b1;
                end
                else if (store_rise)
                begin
                    data_next  = DATA_I;
                    wdata_next = DATA_I;
                    we_next    = 1'b1;
                end
                // Strobe low or held high: nothing new is taken
            end
            default:
            begin
                state_next = rbm_pkg::ST_LOAD;
            end
        endcase
        if (legacy_evt && (state_reg != rbm_pkg::ST_LOAD))
        begin
            data_next  = {NUM_BITS{1'b0}};
            wdata_next = {NUM_BITS{1'b0}};
            we_next    = 1'b1;
        end
        status_next = (state_next == rbm_pkg::ST_RUN);
    end

    // Registers only; CE_I freezes everything
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_reg  <= rbm_pkg::ST_LOAD;
            data_reg   <= `RBM_DATA_RST;
            wdata_reg  <= `RBM_DATA_RST;
            we_reg     <= 1'b0;
            status_reg <= 1'b0;
            armed_reg  <= 1'b0;
        end
        else if (CE_I)
        begin
            state_reg  <= state_next;
            data_reg   <= data_next;
            wdata_reg  <= wdata_next;
            we_reg     <= we_next;
            status_reg <= status_next;
            armed_reg  <= armed_next;
        end
    end

    assign DATA_O     = data_reg;
    assign NV_WDATA_O = wdata_reg;
    assign NV_WE_O    = we_reg;
    assign STATUS_O   = status_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************

    store_write_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && store_rise && !erase_req && !legacy_evt)
        |=> (DATA_O == $past(DATA_I)) && NV_WE_O && (NV_WDATA_O == $past(DATA_I)))
        else $error("store edge did not latch inputs");

    hold_low_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (state_reg == rbm_pkg::ST_RUN && !STORE_I && !legacy_evt)
        |=> $stable(DATA_O) && !NV_WE_O)
        else $error("data changed with store strobe low");

    hold_high_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (state_reg == rbm_pkg::ST_RUN && STORE_I && !store_rise && !CLEAR_I && !legacy_evt)
        |=> $stable(DATA_O))
        else $error("data changed while strobe held high");

    status_run_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (state_reg == rbm_pkg::ST_RUN) == STATUS_O)
        else $error("status does not match running phase");

    load_nv_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && state_reg == rbm_pkg::ST_LOAD && NV_RVALID_I)
        |=> (DATA_O == $past(NV_RDATA_I)) && !NV_WE_O)
        else $error("stored bits not reloaded after power-up");

    no_phantom_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && rearm) |=> (rise == 2'b00))
        else $error("held strobe gave an edge after rearm");

    clear_erase_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && erase_req) |=> (DATA_O == '0) && NV_WE_O && (NV_WDATA_O == '0))
        else $error("clear with store high did not erase");

    clear_gate_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && state_reg != rbm_pkg::ST_LOAD && CLEAR_I && !armed_reg && !clear_rise &&
         !legacy_evt && !store_rise)
        |=> $stable(DATA_O))
        else $error("unarmed clear erased the memory");

    legacy_erase_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && legacy_evt && state_reg != rbm_pkg::ST_LOAD)
        |=> (DATA_O == '0) && NV_WE_O)
        else $error("card pull or project load did not erase");

    tick_only_a: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (state_reg == rbm_pkg::ST_RUN && !LOGIC_TICK_I && !legacy_evt)
        |=> $stable(DATA_O))
        else $error("data changed outside a logic tick");

endmodule : rbm_top

`default_nettype wire

/* File: verif/rbm_nv_model.sv */
/*
 * Non-volatile store model: keeps written bits across RST_I, replays them once.
 * Assumes the block's clock and its power-on reset as the power-loss event.
 */
`timescale 1ns/1ns
`default_nettype none

module rbm_nv_model
#(
    parameter logic [7:0] INIT = 8'h5a
)
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic            rvalid_o
);
    // ****************************************************************
    // Storage and replay
    // ****************************************************************
    logic [7:0] mem_reg = INIT;
    logic [1:0] wait_reg;

    // Storage ignores reset, since reset stands for power loss
    always @(posedge clk_i)
        if (we_i && !rst_i) mem_reg <= wdata_i;

    // Replay two cycles after release, valid one cycle only
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) wait_reg <= 2'h0;
        else if (wait_reg != 2'h3) wait_reg <= wait_reg + 2'h1;
    assign rvalid_o = (wait_reg == 2'h2);

    // Inverse when not valid, so a stale read never looks right
    assign rdata_o = rvalid_o ? mem_reg : ~mem_reg;
endmodule : rbm_nv_model

`default_nettype wire

/* File: verif/test_rbm_top.sv */
/*
 * Self-checking bench for the retentive bit memory top.
 * Assumes the non-volatile store model beside it; reset stands for power loss.
 */
`timescale 1ns/1ns
`default_nettype none

module test_rbm_top;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       tick = 1'b0;
    logic       run = 1'b1;
    logic       store = 1'b0;
    logic       clear = 1'b0;
    logic [7:0] data_in = 8'h00;
    logic       card = 1'b1;
    logic       proj = 1'b0;
    logic [7:0] nv_rdata;
    logic       nv_rvalid;
    logic [7:0] dout;
    logic       status;
    logic       we;
    logic [7:0] wdata;
    int         errors = 0;
    int         n_checks = 0;

    rbm_top rbm_top_inst (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1), .LOGIC_TICK_I(tick),
        .RUN_I(run), .STORE_I(store), .CLEAR_I(clear), .DATA_I(data_in),
        .NV_RDATA_I(nv_rdata), .NV_RVALID_I(nv_rvalid), .CARD_PRESENT_I(card),
        .PROJECT_LOAD_I(proj), .DATA_O(dout), .STATUS_O(status), .NV_WE_O(we),
        .NV_WDATA_O(wdata));

    rbm_nv_model rbm_nv_model_inst (.clk_i(clk), .rst_i(rst), .we_i(we), .wdata_i(wdata),
        .rdata_o(nv_rdata), .rvalid_o(nv_rvalid));

    // Free-running clock, 4 ns period
    initial
    begin
        forever #2 clk = ~clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    // One logic cycle; returns just after the taking edge, while the write pulse stands
    task automatic step(input logic s, input logic c, input logic [7:0] d);
        @(posedge clk);
        store   <= s;
        clear   <= c;
        data_in <= d;
        tick    <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        #1;
    endtask : step

    // Power loss of n+3 cycles; card level c for the first n, back in before power
    task automatic power(input int n, input logic c);
        @(posedge clk);
        rst  <= 1'b1;
        card <= c;
        repeat (n) @(posedge clk);
        card <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : power

    task automatic end_sim();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_store();
        step(1'b0, 1'b0, 8'ha5);
        chk(8'h5a, dout);
        step(1'b1, 1'b0, 8'ha5);
        chk(8'ha5, dout);
        chk(8'h01, {7'h00, we});
        chk(8'ha5, wdata);
        step(1'b1, 1'b0, 8'h3c);
        chk(8'ha5, dout);
        chk(8'h00, {7'h00, we});
        $display("t_store done");
    endtask : t_store

    // Strobe still high across the outage must not store again
    task automatic t_outage();
        power(3, 1'b1);
        chk(8'ha5, dout);
        step(1'b1, 1'b0, 8'hff);
        chk(8'ha5, dout);
        step(1'b0, 1'b0, 8'hff);
        step(1'b1, 1'b0, 8'hff);
        chk(8'hff, dout);
        $display("t_outage done");
    endtask : t_outage

    task automatic t_clear();
        step(1'b0, 1'b1, 8'h11);
        chk(8'hff, dout);
        step(1'b0, 1'b0, 8'h11);
        step(1'b1, 1'b1, 8'h11);
        chk(8'h00, dout);
        chk(8'h00, wdata);
        $display("t_clear done");
    endtask : t_clear

    task automatic t_stop();
        @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(8'h00, {7'h00, status});
        step(1'b0, 1'b0, 8'h99);
        step(1'b1, 1'b0, 8'h99);
        chk(8'h00, dout);
        @(posedge clk);
        run <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(8'h01, {7'h00, status});
        $display("t_stop done");
    endtask : t_stop

    task automatic t_legacy();
        step(1'b0, 1'b0, 8'h66);
        step(1'b1, 1'b0, 8'h66);
        @(posedge clk);
        proj <= 1'b1;
        @(posedge clk);
        proj <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(8'h00, dout);
        step(1'b0, 1'b0, 8'h66);
        step(1'b1, 1'b0, 8'h66);
        @(posedge clk);
        card <= 1'b0;
        repeat (7) @(posedge clk);
        #1;
        chk(8'h00, dout);
        @(posedge clk);
        card <= 1'b1;
        step(1'b0, 1'b0, 8'h3c);
        step(1'b1, 1'b0, 8'h3c);
        power(3, 1'b0);
        chk(8'h3c, dout);
        // After power-up a clear needs its own edge, store high alone is not enough
        step(1'b1, 1'b1, 8'h3c);
        chk(8'h3c, dout);
        step(1'b1, 1'b0, 8'h3c);
        step(1'b1, 1'b1, 8'h3c);
        chk(8'h00, dout);
        $display("t_legacy done");
    endtask : t_legacy

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(8'h5a, dout);
        chk(8'h01, {7'h00, status});
        t_store();
        t_outage();
        t_clear();
        t_stop();
        t_legacy();
        end_sim();
    end

    // Whole run is about a hundred cycles; this cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule : test_rbm_top

`default_nettype wire
